// file: design/set_select_pkg.sv
`default_nettype none

package set_select_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] INDEX_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS = 8'h0c;
  localparam logic [7:0] ACTIVE_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] SLOT_VIEW_OFS = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CFG_COUNT_LSB = 0;
  localparam int CFG_BIT0_SRC_BIT = 4;
  localparam int CFG_BIT1_SRC_BIT = 5;
  localparam int CFG_INV_A_BIT = 6;
  localparam int CFG_INV_B_BIT = 7;
  localparam int CMD_SAVE_BIT = 0;
  localparam int CMD_RESTORE_BIT = 1;
  localparam int STAT_SLOT_LSB = 0;
  localparam int STAT_ADDR_LSB = 2;
  localparam int STAT_ON_BIT = 4;
  localparam int STAT_MISS_BIT = 5;

  // ---------------------------------------------------------------
  // limits and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] MAX_SETS = 3'h4;
  localparam logic [2:0] MIN_SETS = 3'h1;
  localparam logic [2:0] COUNT_RST = 3'h2;
  localparam logic [1:0] SLOT_RST = 2'h0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic {
    SRC_LINE_A,
    SRC_LINE_B
  } line_src_t;

endpackage

`default_nettype wire

// file: design/set_select_top.sv
// Functional notes
// - no fixed stepping; lines choose each set
// - stored set count limited to four
// - two sets: one address bit, either line
// - normal line: high gives bit one
// - inverted line: low gives bit one
// - more sets: two bits, per-bit line choice
// - address decodes as plain binary index
// - target index register accepts zero to three
// - save, only with enable bit clear, copies active set into target slot
// - restore, only with enable bit clear, copies target slot into active set
// - stored sets are volatile
// - trigger: sample, load set, then start
// - enable bit gates trigger-driven selection
`timescale 1ns/100ps
`default_nettype none

module set_select_top #(
  parameter int DATA_W = 32
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic INPUT_LINE_A_IN,
  input wire logic INPUT_LINE_B_IN,
  input wire logic FRAME_TRIG_IN,
  output logic [DATA_W-1:0] ACTIVE_SET_OUT,
  output logic [1:0] ACTIVE_SLOT_OUT,
  output logic ACQ_START_OUT
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] clamp_count(input logic [2:0] v);
    if (v > set_select_pkg::MAX_SETS) begin
      return set_select_pkg::MAX_SETS;
    end else if (v < set_select_pkg::MIN_SETS) begin
      return set_select_pkg::MIN_SETS;
    end
    return v;
  endfunction

  function automatic logic src_level(input logic src, input logic a, input logic b);
    return (src == set_select_pkg::SRC_LINE_B) ? b : a;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [set_select_pkg::SYNC_STAGES-1:0] sync_a_reg;
  logic [set_select_pkg::SYNC_STAGES-1:0] sync_b_reg;
  logic [set_select_pkg::SYNC_STAGES-1:0] sync_t_reg;
  logic trig_prev_reg;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
      sync_t_reg <= '0;
      trig_prev_reg <= 1'b0;
    end else begin
      sync_a_reg <= {sync_a_reg[0], INPUT_LINE_A_IN};
      sync_b_reg <= {sync_b_reg[0], INPUT_LINE_B_IN};
      sync_t_reg <= {sync_t_reg[0], FRAME_TRIG_IN};
      trig_prev_reg <= sync_t_reg[1];
    end
  end

  logic line_a;
  logic line_b;
  logic trig_rise;
  assign trig_rise = sync_t_reg[1] & ~trig_prev_reg;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic set_select_on_reg;
  logic [2:0] stored_set_count_reg;
  logic bit0_line_source_reg;
  logic bit1_line_source_reg;
  logic invert_a_reg;
  logic invert_b_reg;
  logic [1:0] target_set_number_reg;

  logic acc_done;
  logic wr_done;
  assign acc_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr_done = acc_done & PWRITE_IN;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      set_select_on_reg <= 1'b0;
      stored_set_count_reg <= set_select_pkg::COUNT_RST;
      bit0_line_source_reg <= set_select_pkg::SRC_LINE_A;
      bit1_line_source_reg <= set_select_pkg::SRC_LINE_B;
      invert_a_reg <= 1'b0;
      invert_b_reg <= 1'b0;
      target_set_number_reg <= set_select_pkg::SLOT_RST;
    end else if (wr_done) begin
      case (PADDR_IN)
        set_select_pkg::CTRL_OFS: begin
          set_select_on_reg <= PWDATA_IN[set_select_pkg::CTRL_ON_BIT];
        end
        set_select_pkg::CONFIG_OFS: begin
          stored_set_count_reg <=
            clamp_count(PWDATA_IN[set_select_pkg::CFG_COUNT_LSB +: 3]);
          bit0_line_source_reg <= PWDATA_IN[set_select_pkg::CFG_BIT0_SRC_BIT];
          bit1_line_source_reg <= PWDATA_IN[set_select_pkg::CFG_BIT1_SRC_BIT];
          invert_a_reg <= PWDATA_IN[set_select_pkg::CFG_INV_A_BIT];
          invert_b_reg <= PWDATA_IN[set_select_pkg::CFG_INV_B_BIT];
        end
        set_select_pkg::INDEX_OFS: begin
          target_set_number_reg <= PWDATA_IN[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // polarity per line
  assign line_a = sync_a_reg[1] ^ invert_a_reg;
  assign line_b = sync_b_reg[1] ^ invert_b_reg;

  // ---------------------------------------------------------------
  // address formation
  // ---------------------------------------------------------------
  logic [1:0] line_addr;
  always_comb begin
    line_addr[0] = src_level(bit0_line_source_reg, line_a, line_b);
    if (stored_set_count_reg > 3'h2) begin
      line_addr[1] = src_level(bit1_line_source_reg, line_a, line_b);
    end else begin
      line_addr[1] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // commands (write-only pulses)
  // ---------------------------------------------------------------
  logic cmd_hit;
  logic save_cmd;
  logic restore_cmd;
  assign cmd_hit = wr_done & (PADDR_IN == set_select_pkg::CMD_OFS) & ~set_select_on_reg;
  assign save_cmd = cmd_hit & PWDATA_IN[set_select_pkg::CMD_SAVE_BIT];
  assign restore_cmd = cmd_hit & PWDATA_IN[set_select_pkg::CMD_RESTORE_BIT];

  // ---------------------------------------------------------------
  // trigger sequence
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_START
  } trig_state_t;

  trig_state_t state_reg;
  logic [1:0] addr_reg;
  logic miss_reg;

  slot_bus_if #(.DATA_W(DATA_W)) slots ();

  slot_store #(
    .DATA_W(DATA_W),
    .SLOTS(4)
  ) slot_store_inst (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .bus(slots)
  );

  logic [DATA_W-1:0] active_reg;
  assign slots.save = save_cmd;
  assign slots.save_idx = target_set_number_reg;
  assign slots.save_data = active_reg;
  assign slots.pick_idx = addr_reg;
  assign slots.view_idx = target_set_number_reg;

  logic addr_ok;
  assign addr_ok = {1'b0, addr_reg} < stored_set_count_reg;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      addr_reg <= 2'h0;
      miss_reg <= 1'b0;
      ACQ_START_OUT <= 1'b0;
    end else begin
      ACQ_START_OUT <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (trig_rise && set_select_on_reg) begin
            addr_reg <= line_addr;
            state_reg <= ST_LOAD;
          end else if (trig_rise) begin
            state_reg <= ST_START;
          end
        end
        ST_LOAD: begin
          miss_reg <= ~addr_ok;
          state_reg <= ST_START;
        end
        ST_START: begin
          ACQ_START_OUT <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // active parameter set
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      active_reg <= '0;
      ACTIVE_SLOT_OUT <= set_select_pkg::SLOT_RST;
    end else if (state_reg == ST_LOAD && addr_ok) begin
      active_reg <= slots.pick_data;
      ACTIVE_SLOT_OUT <= addr_reg;
    end else if (restore_cmd) begin
      active_reg <= slots.view_data;
      ACTIVE_SLOT_OUT <= target_set_number_reg;
    end else if (wr_done && PADDR_IN == set_select_pkg::ACTIVE_OFS) begin
      active_reg <= PWDATA_IN[DATA_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ACTIVE_SET_OUT <= '0;
    end else begin
      ACTIVE_SET_OUT <= active_reg;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: one wait state, registered
  // ---------------------------------------------------------------
  logic [31:0] rd_next;
  logic hit_next;
  always_comb begin
    rd_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (PADDR_IN)
      set_select_pkg::CTRL_OFS: begin
        rd_next[set_select_pkg::CTRL_ON_BIT] = set_select_on_reg;
      end
      set_select_pkg::CONFIG_OFS: begin
        rd_next[set_select_pkg::CFG_COUNT_LSB +: 3] = stored_set_count_reg;
        rd_next[set_select_pkg::CFG_BIT0_SRC_BIT] = bit0_line_source_reg;
        rd_next[set_select_pkg::CFG_BIT1_SRC_BIT] = bit1_line_source_reg;
        rd_next[set_select_pkg::CFG_INV_A_BIT] = invert_a_reg;
        rd_next[set_select_pkg::CFG_INV_B_BIT] = invert_b_reg;
      end
      set_select_pkg::INDEX_OFS: begin
        rd_next[1:0] = target_set_number_reg;
      end
      set_select_pkg::CMD_OFS: begin
        rd_next = 32'h0000_0000;
      end
      set_select_pkg::ACTIVE_OFS: begin
        rd_next[DATA_W-1:0] = active_reg;
      end
      set_select_pkg::STATUS_OFS: begin
        rd_next[set_select_pkg::STAT_SLOT_LSB +: 2] = ACTIVE_SLOT_OUT;
        rd_next[set_select_pkg::STAT_ADDR_LSB +: 2] = addr_reg;
        rd_next[set_select_pkg::STAT_ON_BIT] = set_select_on_reg;
        rd_next[set_select_pkg::STAT_MISS_BIT] = miss_reg;
      end
      set_select_pkg::SLOT_VIEW_OFS: begin
        rd_next[DATA_W-1:0] = slots.view_data;
      end
      default: begin
        hit_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
      PREADY_OUT <= 1'b1;
      PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_next;
      PSLVERR_OUT <= ~hit_next;
    end else begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: design/slot_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

interface slot_bus_if #(
  parameter int DATA_W = 32
);
  logic save;
  logic [1:0] save_idx;
  logic [DATA_W-1:0] save_data;
  logic [1:0] pick_idx;
  logic [DATA_W-1:0] pick_data;
  logic [1:0] view_idx;
  logic [DATA_W-1:0] view_data;

  modport ctrl (
    output save, save_idx, save_data, pick_idx, view_idx,
    input pick_data, view_data
  );
  modport store (
    input save, save_idx, save_data, pick_idx, view_idx,
    output pick_data, view_data
  );
endinterface

`default_nettype wire

// file: design/slot_store.sv
`timescale 1ns/100ps
`default_nettype none

module slot_store #(
  parameter int DATA_W = 32,
  parameter int SLOTS = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  slot_bus_if.store bus
);

  // ---------------------------------------------------------------
  // stored sets, lost on power down
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] slot_reg [SLOTS];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_reg[i] <= '0;
      end
    end else if (bus.save) begin
      slot_reg[bus.save_idx] <= bus.save_data;
    end
  end

  assign bus.pick_data = slot_reg[bus.pick_idx];
  assign bus.view_data = slot_reg[bus.view_idx];

endmodule

`default_nettype wire

// file: testbench/line_driver.sv
`timescale 1ns/100ps
`default_nettype none

module line_driver (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic a_in,
  input wire logic b_in,
  output logic line_a_out,
  output logic line_b_out,
  output logic trig_out
);
  // -----------------------------------------------------------
  // lines first, trigger only after they settle
  // -----------------------------------------------------------
  initial begin
    line_a_out = 1'b0;
    line_b_out = 1'b0;
    trig_out = 1'b0;
  end

  always @(posedge clk_in) begin
    if (go_in) begin
      line_a_out <= a_in;
      line_b_out <= b_in;
      repeat (260) @(posedge clk_in);
      trig_out <= 1'b1;
      repeat (20) @(posedge clk_in);
      trig_out <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// file: testbench/parameter_set_line_selector_bench.sv
`timescale 1ns/100ps
`default_nettype none

module parameter_set_line_selector_bench;
  logic clk, rst, psel, pen, pwr, go, la, lb, line_a, line_b, trig, rdy, err, acq, e;
  logic [7:0] padr;
  logic [31:0] pwd, prd, rd, seed, act, exp_act, r;
  logic [31:0] vals [4];
  logic [1:0] slot, cur, adr;
  logic [2:0] cnt;
  int errors, n_checks;

  set_select_top set_select_top_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err), .INPUT_LINE_A_IN(line_a), .INPUT_LINE_B_IN(line_b),
    .FRAME_TRIG_IN(trig), .ACTIVE_SET_OUT(act), .ACTIVE_SLOT_OUT(slot), .ACQ_START_OUT(acq));
  line_driver line_driver_inst (.clk_in(clk), .go_in(go), .a_in(la), .b_in(lb),
    .line_a_out(line_a), .line_b_out(line_b), .trig_out(trig));

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [1:0] exp_adr(input logic [2:0] c, input logic s, ia, ib, a, b);
    logic ba, bb, b0, b1;
    ba = a ^ ia;
    bb = b ^ ib;
    b0 = s ? bb : ba;
    b1 = s ? ba : bb;
    return (c > 3'h2) ? {b1, b0} : {1'b0, b0};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      conclude();
    end
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  task automatic fire(input logic a, input logic b);
    int n;
    @(posedge clk);
    n = 0;
    // driver ignores go until its last trigger has fallen
    while (trig !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      conclude();
    end
    la <= a;
    lb <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (acq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      conclude();
    end
  endtask

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    padr = 8'h00;
    pwd = 32'h0;
    go = 1'b0;
    la = 1'b0;
    lb = 1'b0;
    errors = 0;
    n_checks = 0;
    seed = 32'hd73f;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(set_select_pkg::CONFIG_OFS, 32'h22, "config");
    rdc(set_select_pkg::STATUS_OFS, 32'h0, "status");
    apb(1'b0, 8'h1c, 32'h0);
    check("refused read", {31'h0, e}, 32'h1);
    apb(1'b1, 8'h40, 32'h0);
    check("refused write", {31'h0, e}, 32'h1);
    apb(1'b1, set_select_pkg::CONFIG_OFS, 32'h7);
    rdc(set_select_pkg::CONFIG_OFS, 32'h4, "count high");
    apb(1'b1, set_select_pkg::CONFIG_OFS, 32'h0);
    rdc(set_select_pkg::CONFIG_OFS, 32'h1, "count low");
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      vals[i] = xs();
      apb(1'b1, set_select_pkg::ACTIVE_OFS, vals[i]);
      apb(1'b1, set_select_pkg::INDEX_OFS, i);
      apb(1'b1, set_select_pkg::CMD_OFS, 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, set_select_pkg::INDEX_OFS, i);
      rdc(set_select_pkg::INDEX_OFS, i, "index");
      rdc(set_select_pkg::SLOT_VIEW_OFS, vals[i], "slot");
    end
    apb(1'b1, set_select_pkg::ACTIVE_OFS, xs());
    apb(1'b1, set_select_pkg::INDEX_OFS, 32'h2);
    apb(1'b1, set_select_pkg::CMD_OFS, 32'h2);
    rdc(set_select_pkg::ACTIVE_OFS, vals[2], "restored");
    check("restored slot", {30'h0, slot}, 32'h2);
    $display("test store and restore done");
    cur = 2'h2;
    exp_act = ~vals[0];
    apb(1'b1, set_select_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, set_select_pkg::INDEX_OFS, 32'h0);
    apb(1'b1, set_select_pkg::ACTIVE_OFS, exp_act);
    apb(1'b1, set_select_pkg::CMD_OFS, 32'h1);
    apb(1'b1, set_select_pkg::CMD_OFS, 32'h2);
    rdc(set_select_pkg::SLOT_VIEW_OFS, vals[0], "save ignored");
    rdc(set_select_pkg::ACTIVE_OFS, exp_act, "restore ignored");
    $display("test ignored commands done");
    for (int k = 0; k < 24; k++) begin
      r = (k == 0) ? 32'h61 : xs();
      cnt = (r[1:0] == 2'h3) ? 3'h4 : 3'h2 + {1'b0, r[1:0]};
      apb(1'b1, set_select_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, set_select_pkg::CONFIG_OFS, {24'h0, r[4], r[3], ~r[2], r[2], 1'b0, cnt});
      apb(1'b1, set_select_pkg::CTRL_OFS, 32'h1);
      fire(r[5], r[6]);
      adr = exp_adr(cnt, r[2], r[3], r[4], r[5], r[6]);
      if ({1'b0, adr} < cnt) begin
        cur = adr;
        exp_act = vals[adr];
      end
      check("active slot", {30'h0, slot}, {30'h0, cur});
      check("active set", act, exp_act);
      if (k == 0) rdc(set_select_pkg::STATUS_OFS, {26'h0, 6'h3c} | cur, "miss");
    end
    apb(1'b1, set_select_pkg::CTRL_OFS, 32'h0);
    fire(~line_a, ~line_b);
    check("idle slot", {30'h0, slot}, {30'h0, cur});
    check("idle set", act, exp_act);
    $display("test triggers done");
    conclude();
  end
endmodule

`default_nettype wire

// file: testbench/set_select_properties.sv
`timescale 1ns/100ps
`default_nettype none

module set_select_properties (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic FRAME_TRIG_IN,
  input wire logic ACQ_START_OUT
);
  // -----------------------------------------------------------
  // trigger and register bus relations
  // -----------------------------------------------------------
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence trig_rise;
    $rose(FRAME_TRIG_IN);
  endsequence
  sequence acq_pulse;
    ACQ_START_OUT ##1 !ACQ_START_OUT;
  endsequence
  sequence one_wait;
    !PREADY_OUT ##1 PREADY_OUT;
  endsequence

  AST_START_LATENCY: assert property (trig_rise |-> ##[2:8] acq_pulse)
    else $error("acquisition start missing after trigger");
  AST_START_CAUSE: assert property ($rose(ACQ_START_OUT) |-> $past(FRAME_TRIG_IN, 3))
    else $error("acquisition start without trigger");
  AST_READY_WAIT: assert property (PSEL_IN && $rose(PENABLE_IN) |-> one_wait)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  AST_ERR_ONLY_READY: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data outside ready");
  AST_ERR_UNMAPPED: assert property (PREADY_OUT && PADDR_IN > 8'h18 |-> PSLVERR_OUT)
    else $error("unmapped access not refused");
  AST_OK_MAPPED: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN <= 8'h18 &&
    PADDR_IN[1:0] == 2'h0 |-> !PSLVERR_OUT)
    else $error("mapped read refused");
endmodule

bind set_select_top set_select_properties set_select_properties_inst (
  .CLK_SYS_IN(CLK_SYS_IN),
  .RST_IN(RST_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT),
  .FRAME_TRIG_IN(FRAME_TRIG_IN),
  .ACQ_START_OUT(ACQ_START_OUT)
);

`default_nettype wire
